// ### hw/slcs_pkg.sv
// Constants and types shared by the scan-list channel sequencer.
// Assumes a single 20 MHz clock domain and a simple sel/wr/rd register port.
package slcs_pkg;
    localparam int          NUM_CH        = 16;     // Input channels
    localparam int          SRC_W         = 5;      // Source select width
    localparam int          FIFO_DEPTH    = 512;    // Scan-list entries
    localparam int          ID_W          = 8;      // Module ident width
    localparam int          CAL_AW        = 4;      // Calibration word address width
    localparam int          CAL_DW        = 16;     // Calibration word width
    localparam logic [4:0]  CJ_SRC        = 5'h10;  // Cold-junction source code
    localparam logic [4:0]  SRC_RST       = 5'h00;  // Source after reset
    localparam logic [15:0] GAIN_RST      = 16'h0000; // All channels gain 1
    localparam logic [7:0]  MODULE_ID_DEF = 8'h5A;  // Ident value, arbitrary

    // Register offsets on the control port
    localparam logic [2:0]  ADDR_ID       = 3'h0;   // Ident
    localparam logic [2:0]  ADDR_CALA     = 3'h1;   // Calibration address
    localparam logic [2:0]  ADDR_CALD     = 3'h2;   // Calibration data
    localparam logic [2:0]  ADDR_GAIN     = 3'h3;   // Gain bits
    localparam logic [2:0]  ADDR_CPL      = 3'h4;   // Coupling bits
    localparam logic [2:0]  ADDR_CTL      = 3'h5;   // Auto-zero, clear list
    localparam logic [2:0]  ADDR_LIST     = 3'h6;   // List load, current entry
    localparam logic [2:0]  ADDR_STAT     = 3'h7;   // Status

    // Output routing modes
    typedef enum logic [1:0] {
        SLCS_RT_IDLE  = 2'b00,
        SLCS_RT_LOCAL = 2'b01,
        SLCS_RT_TOBUS = 2'b10,
        SLCS_RT_PASS  = 2'b11
    } slcs_route_t;
endpackage

// ### hw/slcs_fifo.sv
// Scan-list memory: write port from controller, circular read port.
// Assumes one clock; reads wrap to entry 0 after the last loaded entry.
`timescale 1ns/1ps
`default_nettype none
module slcs_fifo #(
    parameter int DEPTH = 512,
    parameter int W     = 5
) (
    input  wire logic         ref_clk,     // Clock
    input  wire logic         reset_n,     // Sync reset, low
    input  wire logic         clear,       // Empty the list
    input  wire logic         wr_en,       // Load one entry
    input  wire logic [W-1:0] wr_data,     // Entry to load
    input  wire logic         rd_adv,      // Step to next entry
    input  wire logic         rd_rewind,   // Back to first entry
    output logic      [W-1:0] rd_data,     // Current entry
    output logic              empty,       // No entries loaded
    output logic              full         // List full
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0]  mem [DEPTH];
    logic [AW:0]   cnt_r, cnt_nxt;
    logic [AW-1:0] rp_r, rp_nxt;

    // Next pointers; wrap gives repeated scans
    always_comb begin
        cnt_nxt = cnt_r;
        rp_nxt  = rp_r;
        if (clear) begin
            cnt_nxt = '0;
            rp_nxt  = '0;
        end else begin
            if (wr_en && !full)
                cnt_nxt = cnt_r + 1'b1;
            if (rd_rewind)
                rp_nxt = '0;
            else if (rd_adv && !empty) begin
                if ({1'b0, rp_r} + 1'b1 >= cnt_r)
                    rp_nxt = '0;
                else
                    rp_nxt = rp_r + 1'b1;
            end
        end
    end

    // Registers
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            cnt_r <= '0;
            rp_r  <= '0;
        end else begin
            cnt_r <= cnt_nxt;
            rp_r  <= rp_nxt;
        end
    end

    // Storage in load order
    always_ff @(posedge ref_clk) begin
        if (wr_en && !full && !clear)
            mem[cnt_r[AW-1:0]] <= wr_data;
    end

    assign rd_data = mem[rp_r];
    assign empty   = (cnt_r == '0);
    assign full    = (cnt_r == (AW+1)'(DEPTH));
endmodule
`default_nettype wire

// ### hw/slcs_top.sv
// Scan-list channel sequencer: mux select, gains, coupling, routing.
// Assumes controller signals synchronous to ref_clk; registers reached over the sel/wr/rd/addr port.
// Contract
// - One of 16 channels or cold junction selected at a time.
// - Per-channel gain, 1 or 100.
// - Scan list held in a FIFO loaded by controller, read in order.
// - Entries may name channels in any order.
// - Repeated channels selected each time reached.
// - Scanned but not cabled: drive selection onto backplane bus.
// - Cabled, other module scanned: pass backplane to output pin.
// - Cabled and scanned itself: own channel to output pin.
// - Address decoder with ident, calibration, gain, channel registers.
// - Input switch to connector or ground, forced by auto-zero.
// - Auto-zero grounds all inputs internally.
`timescale 1ns/1ps
`default_nettype none
module slcs_top #(
    parameter int         DEPTH     = slcs_pkg::FIFO_DEPTH,
    parameter logic [7:0] MODULE_ID = slcs_pkg::MODULE_ID_DEF  // Arbitrary ident
) (
    input  wire logic        ref_clk,        // 20 MHz clock
    input  wire logic        reset_n,        // Sync reset, low
    input  wire logic        sel,            // Module addressed
    input  wire logic        wr,             // Write strobe
    input  wire logic        rd,             // Read strobe
    input  wire logic [2:0]  addr,           // Register select
    input  wire logic [15:0] wdata,          // Write data
    output logic      [15:0] rdata,          // Read data
    output logic             rvalid,         // Read data valid pulse
    input  wire logic        scan_adv,       // Conversion advance pulse
    input  wire logic        scan_start,     // Rewind to first entry
    input  wire logic        is_cabled,      // Module cabled to acq device
    input  wire logic        bus_scanned,    // This module owns the scan slot
    output logic      [4:0]  mux_sel,        // Mux source, 16 = cold junction
    output logic      [15:0] gain_hi,        // Gain 100 per channel when 1
    output logic      [15:0] input_ground,   // Input grounded per channel
    output logic             mux_output_pin, // Local source to output pin
    output logic             bus_drive,      // Drive backplane analog bus
    output logic             bus_to_pin      // Backplane bus to output pin
);
    // Register map: 0 ident, 1 cal addr, 2 cal data, 3 gain,
    // 4 coupling, 5 control (bit0 auto-zero, bit1 clear list),
    // 6 scan-list load/current entry, 7 status/mux select.
    localparam logic [2:0] A_ID   = slcs_pkg::ADDR_ID;
    localparam logic [2:0] A_CALA = slcs_pkg::ADDR_CALA;
    localparam logic [2:0] A_CALD = slcs_pkg::ADDR_CALD;
    localparam logic [2:0] A_GAIN = slcs_pkg::ADDR_GAIN;
    localparam logic [2:0] A_CPL  = slcs_pkg::ADDR_CPL;
    localparam logic [2:0] A_CTL  = slcs_pkg::ADDR_CTL;
    localparam logic [2:0] A_LIST = slcs_pkg::ADDR_LIST;
    localparam logic [2:0] A_STAT = slcs_pkg::ADDR_STAT;

    logic [slcs_pkg::CAL_DW-1:0] cal_mem [2**slcs_pkg::CAL_AW];
    logic [3:0]  cal_a_r, cal_a_nxt;
    logic [15:0] gain_r, gain_nxt, cpl_r, cpl_nxt;
    logic        az_r, az_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic        rvalid_r, rvalid_nxt;
    logic [4:0]  sel_r, sel_nxt;
    logic [15:0] gnd_r, gnd_nxt;
    logic        pin_r, pin_nxt, drv_r, drv_nxt, pass_r, pass_nxt;
    slcs_pkg::slcs_route_t route;
    logic [4:0]  entry;
    logic        empty, full;
    logic        list_wr, list_clr;

    // Address decode of write strobes
    assign list_wr  = sel && wr && (addr == A_LIST);
    assign list_clr = sel && wr && (addr == A_CTL) && wdata[1];

    ////////////////////////////////////////////////////////////////////////
    // Scan-list memory
    slcs_fifo #(.DEPTH(DEPTH), .W(slcs_pkg::SRC_W)) u_list (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .clear     (list_clr),
        .wr_en     (list_wr),
        .wr_data   (wdata[4:0]),
        .rd_adv    (scan_adv),
        .rd_rewind (scan_start),
        .rd_data   (entry),
        .empty     (empty),
        .full      (full)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register file next values
    always_comb begin
        cal_a_nxt  = cal_a_r;
        gain_nxt   = gain_r;
        cpl_nxt    = cpl_r;
        az_nxt     = az_r;
        rdata_nxt  = rdata_r;
        rvalid_nxt = 1'b0;
        if (sel && wr) begin
            unique case (addr)
                A_CALA: cal_a_nxt = wdata[3:0];
                A_GAIN: gain_nxt  = wdata;
                A_CPL:  cpl_nxt   = wdata;
                A_CTL:  az_nxt    = wdata[0];
                default: ;
            endcase
        end
        if (sel && rd) begin
            rvalid_nxt = 1'b1;
            unique case (addr)
                A_ID:    rdata_nxt = {8'h00, MODULE_ID};
                A_CALA:  rdata_nxt = {12'h000, cal_a_r};
                A_CALD:  rdata_nxt = cal_mem[cal_a_r];
                A_GAIN:  rdata_nxt = gain_r;
                A_CPL:   rdata_nxt = cpl_r;
                A_CTL:   rdata_nxt = {15'h0000, az_r};
                A_LIST:  rdata_nxt = {11'h000, entry};
                A_STAT:  rdata_nxt = {9'h000, full, empty, sel_r};
            endcase
        end
    end

    // Register file
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            cal_a_r  <= '0;
            gain_r   <= slcs_pkg::GAIN_RST;
            cpl_r    <= 16'h0000;
            az_r     <= 1'b0;
            rdata_r  <= 16'h0000;
            rvalid_r <= 1'b0;
        end else begin
            cal_a_r  <= cal_a_nxt;
            gain_r   <= gain_nxt;
            cpl_r    <= cpl_nxt;
            az_r     <= az_nxt;
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    // Calibration storage
    always_ff @(posedge ref_clk) begin
        if (sel && wr && addr == A_CALD)
            cal_mem[cal_a_r] <= wdata;
    end

    ////////////////////////////////////////////////////////////////////////
    // Routing decision
    always_comb begin
        if (bus_scanned && is_cabled)
            route = slcs_pkg::SLCS_RT_LOCAL;
        else if (bus_scanned)
            route = slcs_pkg::SLCS_RT_TOBUS;
        else if (is_cabled)
            route = slcs_pkg::SLCS_RT_PASS;
        else
            route = slcs_pkg::SLCS_RT_IDLE;
    end

    // Analog control next values
    always_comb begin
        // Entry taken as is: any order, repeats allowed; 17+ codes clamp to cold junction
        if (empty)
            sel_nxt = slcs_pkg::SRC_RST;
        else if (entry > slcs_pkg::CJ_SRC)
            sel_nxt = slcs_pkg::CJ_SRC;
        else
            sel_nxt = entry;
        gnd_nxt  = az_r ? 16'hFFFF : cpl_r;
        pin_nxt  = (route == slcs_pkg::SLCS_RT_LOCAL);
        drv_nxt  = (route == slcs_pkg::SLCS_RT_TOBUS);
        pass_nxt = (route == slcs_pkg::SLCS_RT_PASS);
    end

    // Analog control registers
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            sel_r  <= slcs_pkg::SRC_RST;
            gnd_r  <= 16'h0000;
            pin_r  <= 1'b0;
            drv_r  <= 1'b0;
            pass_r <= 1'b0;
        end else begin
            sel_r  <= sel_nxt;
            gnd_r  <= gnd_nxt;
            pin_r  <= pin_nxt;
            drv_r  <= drv_nxt;
            pass_r <= pass_nxt;
        end
    end

    assign mux_sel        = sel_r;
    assign gain_hi        = gain_r;
    assign input_ground   = gnd_r;
    assign mux_output_pin = pin_r;
    assign bus_drive      = drv_r;
    assign bus_to_pin     = pass_r;
    assign rdata          = rdata_r;
    assign rvalid         = rvalid_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    one_source_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        mux_sel <= slcs_pkg::CJ_SRC) else $error("mux select out of range");
    gain_follow_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        sel && wr && addr == A_GAIN |=> gain_hi == $past(wdata))
        else $error("gain not written");
    sel_follow_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !empty && entry <= slcs_pkg::CJ_SRC |=> mux_sel == $past(entry))
        else $error("mux select does not follow entry");
    az_ground_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        az_r |=> input_ground == 16'hFFFF) else $error("auto-zero not grounded");
    cpl_follow_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !az_r |=> input_ground == $past(cpl_r)) else $error("coupling wrong");
    bus_drive_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        bus_scanned && !is_cabled |=> bus_drive && !mux_output_pin)
        else $error("bus not driven");
    pass_pin_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !bus_scanned && is_cabled |=> bus_to_pin && !bus_drive)
        else $error("bus not passed to pin");
    local_pin_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        bus_scanned && is_cabled |=> mux_output_pin && !bus_to_pin)
        else $error("local not routed to pin");
    id_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        sel && rd && addr == A_ID |=> rvalid && rdata == {8'h00, MODULE_ID})
        else $error("ident read wrong");
    list_load_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        empty && list_wr && !list_clr |=> !empty) else $error("list not loaded");
    rewind_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        scan_start && !list_clr ##1 !empty |-> entry == u_list.mem[0])
        else $error("rewind missed first entry");
endmodule
`default_nettype wire

// ### sim/slcs_chassis_model.sv
// Chassis-side model: cabling level and module scan list slots.
// Assumes the bench loads all eight slots before stepping a scan.
`timescale 1ns/1ps
`default_nettype none
module slcs_chassis_model (
    input  wire logic ref_clk,     // Clock
    input  wire logic reset_n,     // Sync reset, low
    input  wire logic cabled_cfg,  // This module cabled
    input  wire logic slot_wr,     // Load one slot
    input  wire logic slot_bit,    // Slot owned by this module
    input  wire logic slot_step,   // Next slot of the scan
    output logic      is_cabled,   // Cabling level to block
    output logic      bus_scanned  // Scan slot owner level
);
    logic [7:0] slots_r;
    logic [2:0] idx_r;

    ////////////////////////////////////////////////////////////////////////
    // Slot list shifted in before the scan, then stepped in order
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            slots_r <= 8'h00;
            idx_r   <= 3'h0;
        end else if (slot_wr) begin
            slots_r <= {slot_bit, slots_r[7:1]};
            idx_r   <= 3'h0;
        end else if (slot_step) begin
            idx_r <= idx_r + 3'h1;
        end
    end

    // Levels presented to the block
    assign is_cabled   = cabled_cfg;
    assign bus_scanned = slots_r[idx_r];
endmodule
`default_nettype wire

// ### sim/tb_slcs_top.sv
// Bench for the scan-list channel sequencer: registers, scan, routing.
// Assumes the chassis model is compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module tb_slcs_top;
    logic        ref_clk, reset_n, sel, wr, rd, scan_adv, scan_start, rvalid;
    logic        is_cabled, bus_scanned, mux_output_pin, bus_drive, bus_to_pin;
    logic        cabled_cfg, slot_wr, slot_bit, slot_step;
    logic [2:0]  addr;
    logic [4:0]  mux_sel;
    logic [15:0] wdata, rdata, gain_hi, input_ground;
    int          n_errors, total_checks;
    logic [15:0] gains    [3] = '{16'h0001, 16'h8000, 16'hA5C3};
    logic [15:0] cal_d    [2] = '{16'h1234, 16'hBEEF};
    logic [4:0]  load_lst [6] = '{5'h07, 5'h03, 5'h03, slcs_pkg::CJ_SRC, 5'h00, 5'h1F};
    logic [4:0]  scan_exp [7] = '{5'h03, 5'h03, slcs_pkg::CJ_SRC, 5'h00,
                                  slcs_pkg::CJ_SRC, 5'h07, 5'h03};

    ////////////////////////////////////////////////////////////////////////
    // Design and far-side model
    slcs_top #(.DEPTH(6)) i_slcs_top (.ref_clk(ref_clk), .reset_n(reset_n), .sel(sel),
        .wr(wr), .rd(rd), .addr(addr), .wdata(wdata), .rdata(rdata), .rvalid(rvalid),
        .scan_adv(scan_adv), .scan_start(scan_start), .is_cabled(is_cabled),
        .bus_scanned(bus_scanned), .mux_sel(mux_sel), .gain_hi(gain_hi),
        .input_ground(input_ground), .mux_output_pin(mux_output_pin),
        .bus_drive(bus_drive), .bus_to_pin(bus_to_pin));
    slcs_chassis_model i_slcs_chassis_model (.ref_clk(ref_clk), .reset_n(reset_n),
        .cabled_cfg(cabled_cfg), .slot_wr(slot_wr), .slot_bit(slot_bit),
        .slot_step(slot_step), .is_cabled(is_cabled), .bus_scanned(bus_scanned));

    ////////////////////////////////////////////////////////////////////////
    // Compare, wait and access tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #5;
    endtask
    task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
        sel = 1'b1;
        wr = 1'b1;
        addr = a;
        wdata = d;
        tick(1);
        sel = 1'b0;
        wr = 1'b0;
        tick(1);
    endtask
    task automatic rd_reg(input logic [2:0] a, input logic [15:0] exp);
        sel = 1'b1;
        rd = 1'b1;
        addr = a;
        tick(1);
        sel = 1'b0;
        rd = 1'b0;
        for (int i = 0; i < 4 && rvalid !== 1'b1; i++) tick(1);
        check(16'(rvalid), 16'h0001);
        check(rdata, exp);
        tick(1);
    endtask
    task automatic scan_step(input logic start, input logic [4:0] exp);
        scan_start = start;
        scan_adv = ~start;
        tick(1);
        scan_start = 1'b0;
        scan_adv = 1'b0;
        tick(1);
        check(16'(mux_sel), 16'(exp));
    endtask
    task automatic report_and_stop;
        if (n_errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Clock and watchdog
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (3000) @(posedge ref_clk);
        n_errors++;
        report_and_stop();
    end

    // Test sequence
    initial begin
        {reset_n, sel, wr, rd, scan_adv, scan_start} = 6'h00;
        {cabled_cfg, slot_wr, slot_bit, slot_step} = 4'h0;
        addr = 3'h0;
        wdata = 16'h0000;
        tick(12);
        reset_n = 1'b1;
        check(16'({mux_sel, mux_output_pin, bus_drive, bus_to_pin}), 16'h0000);
        wr_reg(3'h0, 16'hFFFF);
        wr_reg(3'h7, 16'hFFFF);
        rd_reg(3'h0, 16'(slcs_pkg::MODULE_ID_DEF));
        rd_reg(3'h7, 16'h0020);
        foreach (gains[i]) begin
            wr_reg(3'h3, gains[i]);
            check(gain_hi, gains[i]);
            rd_reg(3'h3, gains[i]);
        end
        foreach (cal_d[i]) begin
            wr_reg(3'h1, 16'(i * 15));
            wr_reg(3'h2, cal_d[i]);
        end
        foreach (cal_d[i]) begin
            wr_reg(3'h1, 16'(i * 15));
            rd_reg(3'h2, cal_d[i]);
        end
        rd_reg(3'h1, 16'h000F);
        wr_reg(3'h4, 16'h00F0);
        check(input_ground, 16'h00F0);
        rd_reg(3'h4, 16'h00F0);
        wr_reg(3'h5, 16'h0001);
        tick(1);
        check(input_ground, 16'hFFFF);
        rd_reg(3'h5, 16'h0001);
        wr_reg(3'h5, 16'h0000);
        tick(1);
        check(input_ground, 16'h00F0);
        // Scan list from channel assignments, then one refused extra entry
        foreach (load_lst[i]) wr_reg(3'h6, 16'(load_lst[i]));
        scan_step(1'b1, 5'h07);
        rd_reg(3'h6, 16'h0007);
        rd_reg(3'h7, 16'h0047);
        wr_reg(3'h6, 16'h0005);
        foreach (scan_exp[i]) scan_step(1'b0, scan_exp[i]);
        wr_reg(3'h5, 16'h0002);
        rd_reg(3'h7, 16'h0020);
        scan_step(1'b0, 5'h00);
        // Routing for every cabling and scan slot combination
        for (int c = 0; c < 2; c++) begin
            cabled_cfg = c[0];
            slot_wr = 1'b1;
            for (int i = 0; i < 8; i++) begin
                slot_bit = ~i[0];
                tick(1);
            end
            slot_wr = 1'b0;
            for (int s = 0; s < 2; s++) begin
                tick(2);
                check(16'({mux_output_pin, bus_drive, bus_to_pin}),
                      16'({c == 1 && s == 0, c == 0 && s == 0, c == 1 && s == 1}));
                slot_step = 1'b1;
                tick(1);
                slot_step = 1'b0;
            end
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
